// *** verilog/aic_serial_frame_port.sv ***
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// R01: Frame sync falling starts input and output shifting together.
// R02: As master, frame sync stays low exactly sixteen shift-clock periods.
// R03: A slave's external frame sync is low at least one shift-clock period.
// R04: Delayed frame sync copies frame sync length, delayed by programmed periods.
// R05: Master's delayed frame sync feeds a slave's frame sync input.
// R06: End of conversion high during conversion, low until next one.
// R07: Master/slave select high makes master, low makes slave.
// R08: Serial input carries sample and command words, clocked by shift clock.
// R09: Serial output carries conversion results or read-back words.
// R10: The two request inputs ask for secondary talk; unused ones sit low.
// R11: Master divides its clock by four for shift clock; slave takes external.
// R12: Reset clears counters and loads control defaults.
// R13: Sample words are two's complement.
// R14: MSB first; launch on rising shift clock, sample on falling.
module aic_serial_frame_port import aic_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_select,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic frame_sync_n_in,
  output logic frame_sync_n_out,
  output logic frame_sync_n_oe,
  output logic delayed_frame_sync_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic end_of_conversion,
  input wire logic host_request_0,
  input wire logic host_request_1
);
  // ************************************************************
  // Declarations
  // ************************************************************
  frame_state_t state;
  logic [31:0] ctrl, status;
  logic [1:0] div_cnt;
  logic sclk_meta, sclk_sync, sclk_prev, fs_meta, fs_sync;
  logic rise, fall, start, finish, rx_valid, overrun, pos_active, buf_ready, buf_valid;
  logic [4:0] bit_cnt;
  logic [7:0] gap_cnt;
  logic [WORD_BITS-1:0] tx_shift, rx_shift, rx_data, buf_data;
  logic [5:0] pos_cnt, pos_next, fsd_end;
  logic [8:0] conv_cnt;
  logic access, rd_stage, done, wr_done, rd_done, mapped;
  // Address match, used by several decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit
  // ************************************************************
  // Shift clock: divider in master, synchroniser in slave
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
      sclk_out <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      if (div_cnt == 2'h1) begin
        sclk_out <= 1'b1; // [R11]
      end else if (div_cnt == 2'h3) begin
        sclk_out <= 1'b0;
      end
    end
  end
  // Two-stage capture of the external clock and frame sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      fs_meta <= 1'b1;
      fs_sync <= 1'b1;
    end else begin
      sclk_meta <= sclk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      fs_meta <= frame_sync_n_in;
      fs_sync <= fs_meta;
    end
  end
  // Edge pulses by mode
  assign sclk_oe = master_select; // [R07]
  assign frame_sync_n_oe = master_select; // [R07]
  assign rise = master_select ? (div_cnt == 2'h1) : (sclk_sync & ~sclk_prev); // [R11]
  assign fall = master_select ? (div_cnt == 2'h3) : (~sclk_sync & sclk_prev);
  // ************************************************************
  // Frame sequencer
  // ************************************************************
  assign start = (state == ST_IDLE) && rise && ctrl[CTRL_EN_BIT]
                 && (master_select || !fs_sync); // [R01] [R03]
  assign finish = (state == ST_SHIFT) && rise && (bit_cnt == 5'(WORD_BITS)); // [R02]
  // State and bit counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      bit_cnt <= 5'h0;
      gap_cnt <= 8'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_SHIFT; // [R01]
            bit_cnt <= 5'h0;
          end
        end
        ST_SHIFT: begin
          if (finish) begin
            state <= ST_GAP;
            gap_cnt <= 8'h0;
          end else if (fall) begin
            bit_cnt <= bit_cnt + 5'h1;
          end
        end
        ST_GAP: begin
          if (!master_select ? fs_sync : (rise && gap_cnt >= ctrl[CTRL_GAP_LSB +: 8])) begin
            state <= ST_IDLE; // Slave leaves on sync high even with its clock stopped
          end
          if (rise) begin
            gap_cnt <= gap_cnt + 8'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // Frame sync drive, low across the sixteen-bit transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_n_out <= 1'b1;
    end else if (start && master_select) begin
      frame_sync_n_out <= 1'b0; // [R02]
    end else if (finish) begin
      frame_sync_n_out <= 1'b1; // [R02]
    end
  end
  // Transmit shifter, MSB first, launched on rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= '0;
      serial_data_out <= 1'b0;
    end else if (start) begin
      tx_shift <= buf_valid ? buf_data : '0; // [R09] [R13]
      serial_data_out <= buf_valid & buf_data[WORD_BITS-1]; // [R01]
    end else if (finish) begin
      serial_data_out <= 1'b0;
    end else if (state == ST_SHIFT && rise) begin
      tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
      serial_data_out <= tx_shift[WORD_BITS-2]; // [R14]
    end
  end
  // Receive shifter, sampled on falling edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= '0;
      rx_data <= '0;
    end else begin
      if (state == ST_SHIFT && fall) begin
        rx_shift <= {rx_shift[WORD_BITS-2:0], serial_data_in}; // [R08] [R14]
      end
      if (finish) begin
        rx_data <= rx_shift; // [R08]
      end
    end
  end
  // Receive flags; a new word wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (finish) begin
        rx_valid <= 1'b1;
      end else if (rd_done && hit(paddr, ADDR_RXDATA)) begin
        rx_valid <= 1'b0;
      end
      if (finish && rx_valid) begin
        overrun <= 1'b1;
      end else if (wr_done && hit(paddr, ADDR_STATUS) && pwdata[ST_OVR_BIT]) begin
        overrun <= 1'b0;
      end
    end
  end
  // ************************************************************
  // Delayed frame sync for chained slaves
  // ************************************************************
  assign pos_next = pos_cnt + 6'h1;
  assign fsd_end = {1'b0, ctrl[CTRL_FSD_LSB +: 5]} + 6'(WORD_BITS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cnt <= 6'h0;
      pos_active <= 1'b0;
      delayed_frame_sync_n <= 1'b1;
    end else if (start) begin
      pos_cnt <= 6'h0;
      pos_active <= 1'b1;
      delayed_frame_sync_n <= (ctrl[CTRL_FSD_LSB +: 5] != 5'h0); // [R04] [R05]
    end else if (pos_active && rise) begin
      pos_cnt <= pos_next;
      pos_active <= (pos_next < fsd_end);
      delayed_frame_sync_n <= !((pos_next >= {1'b0, ctrl[CTRL_FSD_LSB +: 5]})
                                && (pos_next < fsd_end)); // [R04]
    end
  end
  // ************************************************************
  // Conversion period indicator
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt <= 9'h0;
      end_of_conversion <= 1'b0;
    end else if (finish) begin
      conv_cnt <= 9'(CONV_CYCLES);
      end_of_conversion <= 1'b1; // [R06]
    end else if (conv_cnt != 9'h0) begin
      conv_cnt <= conv_cnt - 9'h1;
      end_of_conversion <= (conv_cnt > 9'h1); // [R06]
    end
  end
  // ************************************************************
  // Transmit buffer between bus writes and the shifter
  // ************************************************************
  tx_buffer #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(wr_done && hit(paddr, ADDR_TXDATA)),
    .in_ready(buf_ready),
    .in_data(pwdata[WORD_BITS-1:0]),
    .out_valid(buf_valid),
    .out_ready(start),
    .out_data(buf_data)
  );
  // ************************************************************
  // APB slave
  // ************************************************************
  assign access = psel & penable;
  assign mapped = hit(paddr, ADDR_CTRL) | hit(paddr, ADDR_STATUS)
                  | hit(paddr, ADDR_TXDATA) | hit(paddr, ADDR_RXDATA);
  // Full buffer stalls a data write; reads take one wait state
  assign pready = pwrite ? !(hit(paddr, ADDR_TXDATA) && !buf_ready) : rd_stage;
  assign done = access & pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign pslverr = done & ~mapped;
  // Live status word
  always_comb begin
    status = 32'h0;
    status[ST_MASTER_BIT] = master_select;
    status[ST_BUSY_BIT] = (state != ST_IDLE);
    status[ST_EOC_BIT] = end_of_conversion;
    status[ST_RXV_BIT] = rx_valid;
    status[ST_OVR_BIT] = overrun;
    status[ST_TXFULL_BIT] = !buf_ready;
    status[ST_REQ0_BIT] = host_request_0; // [R10]
    status[ST_REQ1_BIT] = host_request_1; // [R10]
  end
  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_stage <= 1'b0;
      prdata <= 32'h0;
    end else begin
      rd_stage <= access && !pwrite && !rd_stage;
      if (access && !pwrite && !rd_stage) begin
        case (paddr)
          ADDR_CTRL: prdata <= ctrl;
          ADDR_STATUS: prdata <= status;
          ADDR_RXDATA: prdata <= {16'h0, rx_data};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST; // [R12]
    end else if (wr_done && hit(paddr, ADDR_CTRL)) begin
      ctrl <= pwdata & 32'h00FF_1F01;
    end
  end
  // ************************************************************
  // Checks
  // ************************************************************
  logic [7:0] fs_low_cnt, fsd_low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_low_cnt <= 8'h0;
      fsd_low_cnt <= 8'h0;
    end else begin
      fs_low_cnt <= frame_sync_n_out ? 8'h0 : fs_low_cnt + 8'h1;
      fsd_low_cnt <= delayed_frame_sync_n ? 8'h0 : fsd_low_cnt + 8'h1;
    end
  end
  sequence seq_frame_start;
    start ##1 (state == ST_SHIFT);
  endsequence
  sequence seq_frame_end;
    finish ##1 (state == ST_GAP);
  endsequence
  AST_START_SHIFT: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    start |-> seq_frame_start) else $error("frame did not start shifting");
  AST_FS_SPAN: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    $rose(frame_sync_n_out) && master_select |-> fs_low_cnt == 8'(FRAME_PCLK))
    else $error("frame sync low span wrong");
  AST_FSD_SPAN: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
    $rose(delayed_frame_sync_n) && master_select |-> fsd_low_cnt == 8'(FRAME_PCLK))
    else $error("delayed frame sync span wrong");
  AST_EOC_RISE: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    seq_frame_end |-> end_of_conversion && conv_cnt == 9'(CONV_CYCLES))
    else $error("conversion indicator not raised");
  AST_MODE_DRIVE: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    !frame_sync_n_out |-> frame_sync_n_oe && sclk_oe && state == ST_SHIFT)
    else $error("frame sync driven outside a master frame");
  AST_SCLK_DIV: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    $rose(sclk_out) |-> ##4 $rose(sclk_out)) else $error("shift clock not divide by four");
  AST_RX_WORD: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    finish |=> rx_valid && rx_data == $past(rx_shift)) else $error("word not captured");
  AST_TX_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    start && buf_valid |=> serial_data_out == $past(buf_data[WORD_BITS-1]))
    else $error("first bit not from buffer");
  AST_MSB_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    state == ST_SHIFT && rise && !finish |=> serial_data_out == $past(tx_shift[WORD_BITS-2]))
    else $error("bit order wrong");
endmodule : aic_serial_frame_port

// *** common/aic_pkg.sv ***
package aic_pkg;

  // ************************************************************
  // Serial framing constants
  // ************************************************************
  localparam int WORD_BITS = 16;
  localparam int SCLK_DIV = 4;
  localparam int FRAME_PCLK = WORD_BITS * SCLK_DIV;
  localparam int FIFO_DEPTH = 2;

  // ************************************************************
  // Conversion timing
  // ************************************************************
  localparam int CLK_MHZ = 40;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;

  // Control fields and value after reset
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FSD_LSB = 8;
  localparam int CTRL_GAP_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0020_0101;

  // Status fields
  localparam int ST_MASTER_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_EOC_BIT = 2;
  localparam int ST_RXV_BIT = 3;
  localparam int ST_OVR_BIT = 4;
  localparam int ST_TXFULL_BIT = 5;
  localparam int ST_REQ0_BIT = 6;
  localparam int ST_REQ1_BIT = 7;

  // ************************************************************
  // Frame sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b11
  } frame_state_t;

endpackage : aic_pkg

// *** verilog/tx_buffer.sv ***
`timescale 1ns/1ps

// Small FIFO between register writes and the serial transmitter
module tx_buffer import aic_pkg::*; #(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : tx_buffer

// *** verification/host_port_model.sv ***
`timescale 1ns/1ps

// ************************************************************
// Host serial port model
// ************************************************************
// Far-side serial port: makes framing in slave mode, shifts words both ways
module host_port_model (
  input wire logic pclk,
  input wire logic sclk_line,
  input wire logic fs_line,
  input wire logic dout,
  input wire logic go,
  input wire logic [15:0] tx_word,
  output logic sclk_drv = 1'b0,
  output logic fs_drv = 1'b1,
  output logic din = 1'b0,
  output logic [15:0] rx_word = 16'h0000
);
  logic [8:0] ph = 9'h000;
  logic sclk_d = 1'b0;
  logic [15:0] sh = 16'h0000;

  // Slave framing: 17 clock rises under a low sync and one after it, so the
  // delayed sync can close; the clock stands low between frames
  always @(posedge pclk) begin
    if (ph == 9'h000) begin
      ph <= {8'h00, go};
    end else begin
      ph <= (ph == 9'h120) ? 9'h000 : ph + 9'h001;
    end
    sclk_drv <= (ph >= 9'h008) && (ph < 9'h11C) && ph[3];
    fs_drv <= !((ph != 9'h000) && (ph < 9'h10C));
  end

  // Launch on rising clock, capture on falling clock, MSB first
  always @(posedge pclk) begin
    sclk_d <= sclk_line;
    if (fs_line !== 1'b0) begin
      din <= ~din; // Idle line toggles so no stale bit is seen
      sh <= tx_word;
    end else if (sclk_line && !sclk_d) begin
      din <= sh[15];
      sh <= {sh[14:0], 1'b0};
    end else if (!sclk_line && sclk_d) begin
      rx_word <= {rx_word[14:0], dout};
    end
  end
endmodule : host_port_model

// *** verification/aic_serial_frame_port_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

// ************************************************************
// Testbench top
// ************************************************************
module aic_serial_frame_port_tb import aic_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic master_select = 1'b0;
  logic host_request_0 = 1'b0;
  logic host_request_1 = 1'b0;
  logic go = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, sclk_out, sclk_oe, fs_out, fs_oe, dfs_n, dout, eoc;
  logic sclk_drv, fs_drv, din, err, sclk_line, fs_line;
  logic [15:0] rx_word;
  logic [31:0] rd;
  logic [15:0] exp_w [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h0000};
  int n_errors = 0;
  int samples_checked = 0;
  int d_off, flen, dlen, elen, hi;

  // Shared lines resolved from the DUT's output enables; the host model drives otherwise
  assign sclk_line = sclk_oe ? sclk_out : sclk_drv;
  assign fs_line = fs_oe ? fs_out : fs_drv;

  aic_serial_frame_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_select(master_select), .sclk_in(sclk_line),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_sync_n_in(fs_line),
    .frame_sync_n_out(fs_out), .frame_sync_n_oe(fs_oe), .delayed_frame_sync_n(dfs_n),
    .serial_data_in(din), .serial_data_out(dout), .end_of_conversion(eoc),
    .host_request_0(host_request_0), .host_request_1(host_request_1));

  host_port_model host (.pclk(pclk), .sclk_line(sclk_line), .fs_line(fs_line), .dout(dout),
    .go(go), .tx_word(tx_word), .sclk_drv(sclk_drv), .fs_drv(fs_drv), .din(din),
    .rx_word(rx_word));

  // Clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // One APB transfer; read data and error taken at the accepting edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 1000) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for a frame, then measures sync, delayed sync, clock and conversion spans
  task automatic frame(input int per);
    int i;
    i = 0;
    @(negedge pclk);
    while (fs_line !== 1'b0 && i < 2000) begin
      @(negedge pclk);
      i++;
    end
    if (i == 2000) n_errors++;
    d_off = -1;
    flen = 0;
    dlen = 0;
    elen = 0;
    hi = 0;
    for (i = 0; i < 20 * per + 100; i++) begin
      if (fs_line === 1'b0) flen++;
      if (fs_line === 1'b0 && sclk_line === 1'b1) hi++;
      if (dfs_n === 1'b0 && d_off < 0) d_off = i;
      if (dfs_n === 1'b0) dlen++;
      if (eoc === 1'b1) elen++;
      @(negedge pclk);
    end
  endtask : frame

  // Verdict
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    `CHK(fs_out, 1'b1)
    `CHK(dfs_n, 1'b1)
    `CHK(eoc, 1'b0)
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd, CTRL_RST)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    host_request_0 <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rd[7:6], rd[ST_MASTER_BIT]}, 3'b010)
    host_request_0 <= 1'b0;
    host_request_1 <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[7:6], 2'b10)
    host_request_1 <= 1'b0;
    // Slave frame driven from outside
    apb(1'b1, ADDR_TXDATA, 32'h0000_8001);
    tx_word <= 16'h7FFE;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    frame(16);
    `CHK(dlen, 256)
    `CHK({sclk_oe, fs_oe}, 2'b00)
    `CHK(rx_word, 16'h8001)
    apb(1'b0, ADDR_RXDATA, 32'h0);
    `CHK(rd[15:0], 16'h7FFE)
    // Master frames: full buffer, a write as the first frame starts, then empty buffer
    apb(1'b1, ADDR_CTRL, 32'h0);
    master_select <= 1'b1;
    tx_word <= 16'hA5C3;
    apb(1'b1, ADDR_TXDATA, 32'h0000_1111);
    apb(1'b1, ADDR_TXDATA, 32'h0000_2222);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rd[ST_TXFULL_BIT], rd[ST_MASTER_BIT]}, 2'b11)
    apb(1'b1, ADDR_CTRL, 32'h0020_0301);
    for (int k = 0; k < 4; k++) begin
      if (k == 0) begin
        fork
          apb(1'b1, ADDR_TXDATA, 32'h0000_3333);
          frame(SCLK_DIV);
        join
      end else begin
        frame(SCLK_DIV);
      end
      `CHK(flen, FRAME_PCLK)
      `CHK({d_off, dlen}, {32'd12, FRAME_PCLK})
      `CHK(hi, 32)
      `CHK(elen, CONV_CYCLES)
      `CHK(rx_word, exp_w[k])
      apb(1'b0, ADDR_RXDATA, 32'h0);
      `CHK(rd[15:0], 16'hA5C3)
    end
    // Two unread words raise overrun; a one written to its bit clears it
    frame(SCLK_DIV);
    frame(SCLK_DIV);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rd[ST_OVR_BIT], rd[ST_RXV_BIT]}, 2'b11)
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[ST_OVR_BIT], 1'b0)
    wrap_up();
  end
endmodule : aic_serial_frame_port_tb
